// *** src/smbus_port_map.svh ***
/*
 holds: offsets, reset values and counts of the select-gated register port
 assumes: included by its bare name wherever these names are needed
*/
`ifndef SMBUS_PORT_MAP_SVH
`define SMBUS_PORT_MAP_SVH
// register offsets
`define OFS_DEV 8'h00
`define OFS_RST 8'h01
`define OFS_GPC 8'h02
`define OFS_GPI 8'h05
`define OFS_GPO 8'h06
`define OFS_CFG 8'h20
`define OFS_STAT 8'h30
// reset values
`define DEF_DEV 7'h58
`define DEF_GPC 8'h05
`define DEF_GPO 3'h0
`define DEF_CFG 8'h00
// bits per byte and counter width values
`define SMB_BITS 4'h8
`define SMB_LAST 4'h7
`define SMB_ONE 4'h1
`define PTR_ONE 8'h01
// field positions
`define RST_BIT 0
`define GPC_OE_BIT 0
`endif

// *** src/smbus_port_pkg.sv ***
/*
 holds: state type of the select-gated register port
 assumes: nothing beyond a SystemVerilog compiler
*/
package smbus_port_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK = 3'b010,
      ST_REG = 3'b011,
      ST_DATA = 3'b100,
      ST_RD = 3'b101,
      ST_RDACK = 3'b110,
      ST_WAIT = 3'b111
   } st_e;
endpackage : smbus_port_pkg

// *** src/smbus_line_events.sv ***
/*
 holds: start, stop and clock-edge detection on the two bus lines
 assumes: line levels arrive synchronous to ref_clk_i
*/
`timescale 1ns/1ps
`default_nettype none
module smbus_line_events (
   input wire logic ref_clk_i, // system clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic scl_i, // bus clock level
   input wire logic sda_i, // bus data level
   output logic start_o, // start or repeated start seen
   output logic stop_o, // stop seen
   output logic scl_rise_o, // bus clock rose
   output logic scl_fall_o // bus clock fell
);
   logic scl_reg;
   logic sda_reg;
   logic scl_next;
   logic sda_next;

   // previous line levels
   always_comb begin
      scl_next = scl_i;
      sda_next = sda_i;
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else begin
         scl_reg <= scl_next;
         sda_reg <= sda_next;
      end
   end

   // data edges while clock is high frame a message
   assign start_o = scl_reg & scl_i & sda_reg & ~sda_i;
   assign stop_o = scl_reg & scl_i & ~sda_reg & sda_i;
   assign scl_rise_o = ~scl_reg & scl_i;
   assign scl_fall_o = scl_reg & ~scl_i;
endmodule : smbus_line_events
`default_nettype wire

// *** src/smbus_select_register_port.sv ***
/*
 holds: select-gated bus slave giving byte access to configuration registers
 assumes: lines sampled on ref_clk_i well above bus rate; open-drain wire
 resolved outside from sda_oe_o; link flags come from the serial front end
*/
// Function
// R1: host raises select before any transaction
// R2: write opens with start, address, zero bit
// R3: device acks own address with zero
// R4: register address byte sent and acked
// R5: write data byte stored and acked
// R6: host ends each transaction with stop
// R7: host lowers select after the stop
// R8: read uses repeated start, address, one bit
// R9: read acked, then register contents driven
// R10: host ends read with not-acknowledge
// R11: no address resolution; exact address only
// R12: select may be tied high alone
// R13: shared address needs one select each
// R14: address register and pin chain reprogramming
// R15: link error and loss readable
// R16: select low ignores all bus traffic
// R17: default slave address 1011000
// R18: read-only writes dropped but acknowledged
`timescale 1ns/1ps
`default_nettype none
`include "smbus_port_map.svh"
module smbus_select_register_port (
   input wire logic ref_clk_i, // 40 MHz clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic port_select_i, // port select, active high
   input wire logic scl_i, // bus clock line level
   input wire logic sda_i, // bus data line level
   output logic sda_o, // data drive value, always low
   output logic sda_oe_o, // high while pulling data low
   input wire logic [2:0] gp_in_i, // general pin input levels
   input wire logic link_err_i, // error on active serial input
   input wire logic link_loss_i, // link lost on active input
   output logic general_pin_zero_o, // chain pin value
   output logic general_pin_zero_oe_o, // chain pin output enable
   output logic [7:0] dev_cfg_o, // device configuration byte
   output logic soft_reset_o // one-cycle software reset
);
   import smbus_port_pkg::*;

   logic start;
   logic stop;
   logic scl_rise;
   logic scl_fall;
   st_e st_reg, st_next, ph_reg, ph_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg, sh_next;
   logic [7:0] tx_reg, tx_next;
   logic [7:0] ptr_reg, ptr_next;
   logic oe_reg, oe_next;
   logic [6:0] dev_reg, dev_next;
   logic [7:0] gpc_reg, gpc_next;
   logic [2:0] gpo_reg, gpo_next;
   logic [7:0] cfg_reg, cfg_next;
   logic [1:0] stat_reg, stat_next;
   logic srst_reg, srst_next;

   // line event detection
   smbus_line_events u_events (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .start_o(start),
      .stop_o(stop),
      .scl_rise_o(scl_rise),
      .scl_fall_o(scl_fall)
   );

   // register contents seen by a read
   function automatic logic [7:0] read_mux(input logic [7:0] a);
      case (a)
         `OFS_DEV: read_mux = {dev_reg, 1'b0};
         `OFS_GPC: read_mux = gpc_reg;
         `OFS_GPI: read_mux = {5'h00, gp_in_i};
         `OFS_GPO: read_mux = {5'h00, gpo_reg};
         `OFS_CFG: read_mux = cfg_reg;
         `OFS_STAT: read_mux = {6'h00, stat_reg}; // [R15]
         default: read_mux = 8'h00;
      endcase
   endfunction : read_mux

   // byte engine and register writes
   always_comb begin
      st_next = st_reg;
      ph_next = ph_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      tx_next = tx_reg;
      ptr_next = ptr_reg;
      oe_next = oe_reg;
      dev_next = dev_reg;
      gpc_next = gpc_reg;
      gpo_next = gpo_reg;
      cfg_next = cfg_reg;
      srst_next = 1'b0;
      stat_next = {link_loss_i, link_err_i}; // [R15]
      if (srst_reg) begin
         gpc_next = `DEF_GPC; // address register survives
         gpo_next = `DEF_GPO;
         cfg_next = `DEF_CFG;
      end
      if (!port_select_i) begin // [R16] [R1] [R7] [R13]
         st_next = ST_IDLE;
         oe_next = 1'b0;
         cnt_next = 4'h0;
      end else if (start) begin // [R2] [R8]
         st_next = ST_ADDR;
         oe_next = 1'b0;
         cnt_next = 4'h0;
      end else if (stop) begin // [R6]
         st_next = ST_IDLE;
         oe_next = 1'b0;
      end else begin
         case (st_reg)
            ST_ADDR, ST_REG, ST_DATA: begin
               if (scl_rise) begin
                  sh_next = {sh_reg[6:0], sda_i};
                  cnt_next = cnt_reg + `SMB_ONE;
               end else if (scl_fall && cnt_reg == `SMB_BITS) begin
                  cnt_next = 4'h0;
                  oe_next = 1'b1; // [R3] [R4] [R5]
                  st_next = ST_ACK;
                  if (st_reg == ST_ADDR) begin
                     if (sh_reg[7:1] != dev_reg) begin // [R11] [R17]
                        oe_next = 1'b0;
                        st_next = ST_WAIT;
                     end else begin
                        ph_next = sh_reg[0] ? ST_RD : ST_REG; // [R2] [R8]
                     end
                  end else if (st_reg == ST_REG) begin
                     ptr_next = sh_reg; // [R4]
                     ph_next = ST_DATA;
                  end else begin
                     ptr_next = ptr_reg + `PTR_ONE;
                     ph_next = ST_DATA;
                     case (ptr_reg) // [R5]
                        `OFS_DEV: dev_next = sh_reg[7:1]; // [R14]
                        `OFS_RST: srst_next = sh_reg[`RST_BIT];
                        `OFS_GPC: gpc_next = sh_reg;
                        `OFS_GPO: gpo_next = sh_reg[2:0]; // [R14]
                        `OFS_CFG: cfg_next = sh_reg;
                        default: ; // [R18]
                     endcase
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  st_next = ph_reg;
                  oe_next = 1'b0;
                  if (ph_reg == ST_RD) begin
                     tx_next = read_mux(ptr_reg); // [R9]
                     oe_next = ~tx_next[7];
                  end
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  tx_next = {tx_reg[6:0], 1'b0};
                  if (cnt_reg == `SMB_LAST) begin
                     cnt_next = 4'h0;
                     oe_next = 1'b0;
                     st_next = ST_RDACK;
                  end else begin
                     cnt_next = cnt_reg + `SMB_ONE;
                     oe_next = ~tx_reg[6]; // [R9]
                  end
               end
            end
            ST_RDACK: begin
               if (scl_rise) begin
                  if (sda_i) begin
                     st_next = ST_WAIT; // [R10]
                  end else begin
                     ptr_next = ptr_reg + `PTR_ONE;
                     ph_next = ST_RD;
                     st_next = ST_ACK;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg <= ST_IDLE;
         ph_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         sh_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         oe_reg <= 1'b0;
         dev_reg <= `DEF_DEV;
         gpc_reg <= `DEF_GPC;
         gpo_reg <= `DEF_GPO;
         cfg_reg <= `DEF_CFG;
         stat_reg <= 2'h0;
         srst_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         ph_reg <= ph_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         tx_reg <= tx_next;
         ptr_reg <= ptr_next;
         oe_reg <= oe_next;
         dev_reg <= dev_next;
         gpc_reg <= gpc_next;
         gpo_reg <= gpo_next;
         cfg_reg <= cfg_next;
         stat_reg <= stat_next;
         srst_reg <= srst_next;
      end
   end

   // outputs straight from flip-flops, except sda_o, which is tied low
   assign sda_o = 1'b0;
   assign sda_oe_o = oe_reg;
   assign general_pin_zero_o = gpo_reg[0]; // [R14]
   assign general_pin_zero_oe_o = gpc_reg[`GPC_OE_BIT];
   assign dev_cfg_o = cfg_reg;
   assign soft_reset_o = srst_reg;

   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);

   logic byte_end;
   assign byte_end = port_select_i && !start && !stop && scl_fall && cnt_reg == `SMB_BITS;

   property p_addr_ack;
      byte_end && st_reg == ST_ADDR && sh_reg[7:1] == dev_reg |=> sda_oe_o && !sda_o;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acked"); // [R3]

   property p_foreign_addr;
      byte_end && st_reg == ST_ADDR && sh_reg[7:1] != dev_reg |=> !sda_oe_o [*2];
   endproperty
   a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address acked"); // [R11]

   property p_reg_ack;
      byte_end && st_reg == ST_REG |=> sda_oe_o && ptr_reg == $past(sh_reg);
   endproperty
   a_reg_ack: assert property (p_reg_ack) else $error("register byte not taken"); // [R4]

   property p_write_store;
      byte_end && st_reg == ST_DATA && ptr_reg == `OFS_GPO
      |=> sda_oe_o && general_pin_zero_o == $past(sh_reg[0]);
   endproperty
   a_write_store: assert property (p_write_store) else $error("write not stored"); // [R5]

   property p_ro_write;
      byte_end && st_reg == ST_DATA && ptr_reg == `OFS_STAT
      |=> sda_oe_o && $stable(gpo_reg) && $stable(cfg_reg) && $stable(dev_reg);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write changed state"); // [R18]

   property p_read_load;
      port_select_i && !start && !stop && st_reg == ST_ACK && ph_reg == ST_RD && scl_fall
      |=> tx_reg == read_mux($past(ptr_reg)) && sda_oe_o == !tx_reg[7];
   endproperty
   a_read_load: assert property (p_read_load) else $error("read byte wrong"); // [R9]

   property p_deselect;
      !port_select_i |=> !sda_oe_o && st_reg == ST_IDLE;
   endproperty
   a_deselect: assert property (p_deselect) else $error("deselected port active"); // [R16]

   property p_status;
      port_select_i && link_err_i && link_loss_i |=> stat_reg == 2'h3 ##1 1'b1;
   endproperty
   a_status: assert property (p_status) else $error("link status not captured"); // [R15]

   property p_addr_reprog;
      byte_end && st_reg == ST_DATA && ptr_reg == `OFS_DEV |=> dev_reg == $past(sh_reg[7:1]);
   endproperty
   a_addr_reprog: assert property (p_addr_reprog) else $error("address not reprogrammed"); // [R14]
endmodule : smbus_select_register_port
`default_nettype wire

// *** bench/smbus_host_model.sv ***
/*
 holds: bus host model giving start, stop, byte write and byte read
 assumes: sda_line_i is the pulled-up wire; tasks are entered at a falling clock edge
*/
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
   input wire logic ref_clk_i, // bench clock
   input wire logic sda_line_i, // resolved data wire
   output logic scl_o, // bus clock, idle high
   output logic sda_o // data drive, 1 releases
);
   localparam int HALF = 4;
   // bus idles released
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic gap(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : gap
   // one clock pulse, wire sampled late in the high phase
   task automatic bit_cyc(input logic b, output logic s);
      gap(1);
      sda_o = b;
      gap(HALF);
      scl_o = 1'b1;
      gap(HALF);
      s = sda_line_i;
      scl_o = 1'b0;
   endtask : bit_cyc
   // start or repeated start: data falls while clock high
   task automatic start_cond;
      gap(1);
      sda_o = 1'b1;
      gap(HALF);
      scl_o = 1'b1;
      gap(HALF);
      sda_o = 1'b0;
      gap(HALF);
      scl_o = 1'b0;
   endtask : start_cond
   // stop: data rises while clock high, then idle
   task automatic stop_cond;
      gap(1);
      sda_o = 1'b0;
      gap(HALF);
      scl_o = 1'b1;
      gap(HALF);
      sda_o = 1'b1;
      gap(HALF);
   endtask : stop_cond
   // byte out msb first, ack read on the ninth pulse
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(b[i], s);
      end
      bit_cyc(1'b1, ack);
   endtask : put_byte
   // byte in; the last one is answered with not-acknowledge
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b1, s);
         b[i] = s;
      end
      bit_cyc(last, s);
   endtask : get_byte
endmodule : smbus_host_model
`default_nettype wire

// *** bench/smbus_select_register_port_test.sv ***
/*
 holds: self-checking bench for the select-gated register port
 assumes: host model shares ref_clk_i; data wire has a pull-up
*/
`timescale 1ns/1ps
`default_nettype none
module smbus_select_register_port_test;
   localparam int LIMIT = 40000;
   logic ref_clk_i, arst_n_i, port_select_i, link_err_i, link_loss_i;
   logic [2:0] gp_in_i;
   logic scl, host_sda, sda_line, dev_sda, sda_oe, pin0, pin0_oe, soft_rst;
   logic [7:0] dev_cfg, m_pcfg, m_cfg;
   logic [6:0] m_addr;
   logic [2:0] m_gpo;
   logic [7:0] offs [5] = '{8'h02, 8'h05, 8'h06, 8'h20, 8'h30};
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   // open-drain wire: low when either side pulls
   assign sda_line = host_sda & ~sda_oe;
   smbus_select_register_port uut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
      .port_select_i(port_select_i), .scl_i(scl), .sda_i(sda_line), .sda_o(dev_sda),
      .sda_oe_o(sda_oe), .gp_in_i(gp_in_i), .link_err_i(link_err_i),
      .link_loss_i(link_loss_i), .general_pin_zero_o(pin0),
      .general_pin_zero_oe_o(pin0_oe), .dev_cfg_o(dev_cfg), .soft_reset_o(soft_rst));
   smbus_host_model host (.ref_clk_i(ref_clk_i), .sda_line_i(sda_line), .scl_o(scl),
      .sda_o(host_sda));
   always #12.5 ref_clk_i = ~ref_clk_i;
   // hang guard
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      if (miscompares == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // expected contents from the bench's own register copy
   function automatic logic [7:0] exp_reg(input logic [7:0] r);
      case (r)
         8'h00: exp_reg = {m_addr, 1'b0};
         8'h02: exp_reg = m_pcfg;
         8'h05: exp_reg = {5'h00, gp_in_i};
         8'h06: exp_reg = {5'h00, m_gpo};
         8'h20: exp_reg = m_cfg;
         8'h30: exp_reg = {6'h00, link_loss_i, link_err_i};
         default: exp_reg = 8'h00;
      endcase
   endfunction : exp_reg
   // sel[0]: select during the transfer, sel[1]: select left after it
   task automatic wr_reg(input logic [1:0] sel, input logic [6:0] a, input logic [7:0] r, d,
      output logic [2:0] nk);
      port_select_i = sel[0];
      host.start_cond();
      host.put_byte({a, 1'b0}, nk[2]);
      host.put_byte(r, nk[1]);
      host.put_byte(d, nk[0]);
      host.stop_cond();
      port_select_i = sel[1];
      host.gap(2);
   endtask : wr_reg
   task automatic rd_reg(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d,
      output logic [2:0] nk);
      port_select_i = 1'b1;
      host.start_cond();
      host.put_byte({a, 1'b0}, nk[2]);
      host.put_byte(r, nk[1]);
      host.start_cond();
      host.put_byte({a, 1'b1}, nk[0]);
      host.get_byte(1'b1, d);
      host.stop_cond();
      port_select_i = 1'b0;
      host.gap(2);
   endtask : rd_reg
   // write, mirror, check outputs, then read back
   task automatic wr_chk(input logic [7:0] r, d);
      logic [2:0] nk;
      logic [7:0] q;
      gp_in_i = 3'($urandom);
      link_err_i = 1'($urandom);
      link_loss_i = 1'($urandom);
      wr_reg(2'b01, m_addr, r, d, nk);
      chk({5'h00, nk}, 8'h00);
      case (r)
         8'h00: m_addr = d[7:1];
         8'h01: begin
            if (d[0]) begin
               m_pcfg = 8'h05;
               m_gpo = 3'h0;
               m_cfg = 8'h00;
            end
         end
         8'h02: m_pcfg = d;
         8'h06: m_gpo = d[2:0];
         8'h20: m_cfg = d;
         default: ;
      endcase
      chk(dev_cfg, m_cfg);
      chk({6'h00, pin0_oe, pin0}, {6'h00, m_pcfg[0], m_gpo[0]});
      rd_reg(m_addr, r, q, nk);
      chk({5'h00, nk}, 8'h00);
      chk(q, exp_reg(r));
   endtask : wr_chk
   initial begin
      logic [2:0] nk;
      logic [7:0] q;
      ref_clk_i = 1'b0;
      arst_n_i = 1'b0;
      port_select_i = 1'b0;
      gp_in_i = 3'h0;
      link_err_i = 1'b0;
      link_loss_i = 1'b0;
      m_addr = 7'h58;
      m_pcfg = 8'h05;
      m_gpo = 3'h0;
      m_cfg = 8'h00;
      void'($urandom(72352));
      repeat (10) @(negedge ref_clk_i);
      chk({3'h0, dev_sda, sda_oe, pin0, pin0_oe, soft_rst}, 8'h02);
      chk(dev_cfg, 8'h00);
      arst_n_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      // corners: chain pin, read-only, unmapped, new slave address
      wr_chk(8'h06, 8'h01);
      wr_chk(8'h30, 8'hff);
      wr_chk(8'h05, 8'hff);
      wr_chk(8'h7f, 8'h5a);
      wr_chk(8'h02, 8'hf0);
      wr_chk(8'h01, 8'h01);
      wr_chk(8'h00, 8'h46);
      rd_reg(7'h58, 8'h00, q, nk);
      chk({5'h00, nk}, 8'h07);
      wr_chk(8'h00, 8'hb0);
      wr_reg(2'b00, 7'h58, 8'h20, 8'h3c, nk);
      chk({5'h00, nk}, 8'h07);
      chk(dev_cfg, m_cfg);
      // select held high across two transactions
      wr_reg(2'b11, 7'h58, 8'h20, 8'h3c, nk);
      chk({5'h00, nk}, 8'h00);
      m_cfg = 8'h3c;
      rd_reg(7'h58, 8'h20, q, nk);
      chk(q, 8'h3c);
      chk(dev_cfg, m_cfg);
      for (int i = 0; i < 12; i++) begin
         wr_chk(offs[$urandom_range(4, 0)], 8'($urandom));
      end
      wrap_up();
   end
endmodule : smbus_select_register_port_test
`default_nettype wire
